// File: pkg/mrc_pkg.sv
// What this block does
// R1: 14-bit max length, default 1518, abort longer; with select 1 the code flags them oversize and cuts only at 11265
// R2: watchdog cuts frames beyond 11264 bytes always
// R3: select 0: cut at max+1, flag oversize
// R4: select 1: cut at 11265, oversize plus cut flag
// R5: strip on removes last four bytes
// R6: tag check off: one limit for all frames
// R7: tag check on: +4 single, +8 double tag
// R8: frames accepted only while receiver_on set
// R9: disable waits for current frame to finish
// R10: disabled flag set on completion, write-one clears
// R11: software keeps settings stable while receiving
// R12: reserved bits read zero, writes ignored
`default_nettype none
package mrc_pkg;
  localparam logic [11:0] MRC_CTRL_OFS = 12'h104;
  localparam logic [11:0] MRC_IRQ_STS_OFS = 12'h120;
  localparam logic [11:0] MRC_IRQ_MASK_OFS = 12'h124;
  localparam int MRC_MAX_LSB = 16;
  localparam int MRC_MAX_W = 14;
  localparam int MRC_WTL_BIT = 5;
  localparam int MRC_STRIP_BIT = 4;
  localparam int MRC_TAG_BIT = 2;
  localparam int MRC_DIS_BIT = 1;
  localparam int MRC_ON_BIT = 0;
  localparam logic [13:0] MRC_MAX_RST = 14'h05EE;
  localparam logic MRC_WTL_RST = 1'b1;
  localparam int unsigned MRC_WDT_LEN = 11264;
  localparam int MRC_FCS_BYTES = 4;
  localparam logic [14:0] MRC_TAG_EXTRA = 15'h0004;
  localparam logic [15:0] MRC_TPID_C = 16'h8100;
  localparam logic [15:0] MRC_TPID_S = 16'h88A8;
  localparam logic [14:0] MRC_TAG1_IDX = 15'h000D;
  localparam logic [14:0] MRC_TAG2_IDX = 15'h0011;
  localparam int MRC_ST_LONG_BIT = 14;
  localparam int MRC_ST_CUT_BIT = 15;
  localparam int MRC_ST_ERR_BIT = 16;
  localparam int MRC_IRQ_DONE = 0;
  localparam int MRC_IRQ_LONG = 1;
  localparam int MRC_IRQ_CUT = 2;
  localparam int MRC_IRQ_DIS = 3;
  localparam int MRC_IRQ_W = 4;
  typedef enum logic [1:0] {MRC_IDLE, MRC_RECV, MRC_DROP} mrc_state_t;
endpackage : mrc_pkg
`default_nettype wire

// File: pkg/mrc_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mrc_cfg_if;
  logic [13:0] max_size;
  logic strip;
  logic tag_aware;
  logic vld;
  logic sof;
  logic [7:0] data;
  logic [14:0] idx;
  modport src (output max_size, strip, tag_aware, vld, sof, data, idx);
  modport snk (input max_size, strip, tag_aware, vld, sof, data, idx);
endinterface : mrc_cfg_if
`default_nettype wire

// File: hdl/mrc_tag_limit.sv
`timescale 1ns/1ps
`default_nettype none
module mrc_tag_limit (
  input wire logic sys_clk,
  input wire logic sys_rst,
  mrc_cfg_if.snk cfg,
  output logic [14:0] allowed
);
  logic [7:0] prev_q, prev_d;
  logic tag1_q, tag1_d, tag2_q, tag2_d;
  logic [15:0] pair;

  always_comb begin
    pair = {prev_q, cfg.data};
    prev_d = prev_q;
    tag1_d = cfg.sof ? 1'b0 : tag1_q;
    tag2_d = cfg.sof ? 1'b0 : tag2_q;
    if (cfg.vld) begin
      prev_d = cfg.data;
      if (cfg.idx == mrc_pkg::MRC_TAG1_IDX &&
          (pair == mrc_pkg::MRC_TPID_C || pair == mrc_pkg::MRC_TPID_S)) begin
        tag1_d = 1'b1;
      end
      if (cfg.idx == mrc_pkg::MRC_TAG2_IDX && tag1_q &&
          (pair == mrc_pkg::MRC_TPID_C || pair == mrc_pkg::MRC_TPID_S)) begin
        tag2_d = 1'b1;
      end
    end
    allowed = {1'b0, cfg.max_size}; // [R6]
    if (cfg.tag_aware) begin
      allowed = {1'b0, cfg.max_size}
                + (tag1_q ? mrc_pkg::MRC_TAG_EXTRA : 15'h0000)
                + (tag2_q ? mrc_pkg::MRC_TAG_EXTRA : 15'h0000); // [R7]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prev_q <= 8'h00;
      tag1_q <= 1'b0;
      tag2_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
      tag1_q <= tag1_d;
      tag2_q <= tag2_d;
    end
  end
endmodule : mrc_tag_limit
`default_nettype wire

// File: hdl/mrc_fcs_strip.sv
`timescale 1ns/1ps
`default_nettype none
module mrc_fcs_strip (
  input wire logic sys_clk,
  input wire logic sys_rst,
  mrc_cfg_if.snk cfg,
  output logic out_valid,
  output logic [7:0] out_data
);
  localparam int DEPTH = mrc_pkg::MRC_FCS_BYTES;
  logic [7:0] dly_q [DEPTH];
  logic [7:0] dly_d [DEPTH];
  logic [2:0] fill_q, fill_d;
  logic [2:0] base;
  logic vld_d;
  logic [7:0] data_d;

  always_comb begin
    dly_d = dly_q;
    fill_d = fill_q;
    vld_d = 1'b0;
    data_d = out_data;
    base = cfg.sof ? 3'h0 : fill_q;
    if (cfg.vld) begin
      if (!cfg.strip) begin
        vld_d = 1'b1;
        data_d = cfg.data;
      end else begin
        // the newest four bytes are held back; at frame end they are the fcs
        if (base == 3'(DEPTH)) begin
          vld_d = 1'b1;
          data_d = dly_q[DEPTH-1]; // [R5]
        end else begin
          fill_d = base + 3'h1;
        end
        for (int i = DEPTH - 1; i > 0; i--) begin
          dly_d[i] = dly_q[i-1];
        end
        dly_d[0] = cfg.data;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      fill_q <= 3'h0;
      out_valid <= 1'b0;
      out_data <= 8'h00;
      for (int i = 0; i < DEPTH; i++) begin
        dly_q[i] <= 8'h00;
      end
    end else begin
      fill_q <= fill_d;
      out_valid <= vld_d;
      out_data <= data_d;
      dly_q <= dly_d;
    end
  end
endmodule : mrc_fcs_strip
`default_nettype wire

// File: hdl/mrc_rx_ctrl.sv
// Chosen here: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module mrc_rx_ctrl #(
  parameter int unsigned WDT_LEN = mrc_pkg::MRC_WDT_LEN
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic phy_rx_dv,
  input wire logic phy_rx_er,
  input wire logic [7:0] phy_rx_data,
  output logic rx_data_valid,
  output logic [7:0] rx_data,
  output logic rx_status_valid,
  output logic [31:0] rx_status_word_a,
  output logic irq
);
  localparam logic [14:0] CUT_LEN = 15'(WDT_LEN + 1);

  if (WDT_LEN < 64 || WDT_LEN > 16382) begin : g_chk
    $error("WDT_LEN outside the range of the 14-bit length counter");
  end

  function automatic logic [31:0] mrc_be_mask(input logic [3:0] be);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction : mrc_be_mask

  function automatic logic [31:0] mrc_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
    logic [31:0] m;
    m = mrc_be_mask(be);
    return (old & ~m) | (wd & m);
  endfunction : mrc_merge

  // register bus: one wait cycle, then a single acknowledge cycle
  logic ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic access;
  logic wr_ev;
  logic [31:0] wmask;
  logic [31:0] wbits;
  logic [31:0] ctrl_word;
  logic [31:0] ctrl_new;
  logic [31:0] mask_new;

  // control and status
  logic [13:0] max_q, max_d;
  logic wtl_q, wtl_d;
  logic strip_q, strip_d;
  logic tag_q, tag_d;
  logic on_q, on_d;
  logic dis_q, dis_d;
  logic [mrc_pkg::MRC_IRQ_W-1:0] sts_q, sts_d;
  logic [mrc_pkg::MRC_IRQ_W-1:0] mask_q, mask_d;
  logic [mrc_pkg::MRC_IRQ_W-1:0] evt;

  // frame path
  mrc_pkg::mrc_state_t state_q, state_d;
  logic [14:0] cnt_q, cnt_d;
  logic [14:0] base;
  logic [14:0] next_len;
  logic [14:0] cut_len;
  logic [14:0] allowed;
  logic prev_dv_q, prev_dv_d;
  logic er_q, er_d;
  logic on_prev_q, on_prev_d;
  logic pend_q, pend_d;
  logic st_vld_d;
  logic [31:0] st_word_d;
  logic start;
  logic take;
  logic done_long;
  logic done_cut;

  mrc_cfg_if cfg ();

  assign access = avs_read | avs_write;
  assign avs_waitrequest = access & ~ack_q;
  assign avs_readdata = rdata_q;
  assign wr_ev = avs_write & ack_q;
  assign wmask = mrc_be_mask(avs_byteenable);
  assign wbits = avs_writedata & wmask;
  assign irq = |(sts_q & mask_q);

  always_comb begin
    ctrl_word = 32'h0000_0000; // [R12]
    ctrl_word[mrc_pkg::MRC_MAX_LSB +: mrc_pkg::MRC_MAX_W] = max_q;
    ctrl_word[mrc_pkg::MRC_WTL_BIT] = wtl_q;
    ctrl_word[mrc_pkg::MRC_STRIP_BIT] = strip_q;
    ctrl_word[mrc_pkg::MRC_TAG_BIT] = tag_q;
    ctrl_word[mrc_pkg::MRC_DIS_BIT] = dis_q;
    ctrl_word[mrc_pkg::MRC_ON_BIT] = on_q;
    ctrl_new = mrc_merge(ctrl_word, avs_writedata, avs_byteenable);
    mask_new = mrc_merge(32'(mask_q), avs_writedata, avs_byteenable);
  end

  always_comb begin
    ack_d = access & ~ack_q;
    rdata_d = rdata_q;
    if (avs_read && !ack_q) begin
      case (avs_address)
        mrc_pkg::MRC_CTRL_OFS: rdata_d = ctrl_word;
        mrc_pkg::MRC_IRQ_STS_OFS: rdata_d = 32'(sts_q);
        mrc_pkg::MRC_IRQ_MASK_OFS: rdata_d = 32'(mask_q);
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    max_d = max_q;
    wtl_d = wtl_q;
    strip_d = strip_q;
    tag_d = tag_q;
    on_d = on_q;
    mask_d = mask_q;
    if (wr_ev && avs_address == mrc_pkg::MRC_CTRL_OFS) begin
      max_d = ctrl_new[mrc_pkg::MRC_MAX_LSB +: mrc_pkg::MRC_MAX_W]; // [R1]
      wtl_d = ctrl_new[mrc_pkg::MRC_WTL_BIT];
      strip_d = ctrl_new[mrc_pkg::MRC_STRIP_BIT];
      tag_d = ctrl_new[mrc_pkg::MRC_TAG_BIT];
      on_d = ctrl_new[mrc_pkg::MRC_ON_BIT];
    end
    if (wr_ev && avs_address == mrc_pkg::MRC_IRQ_MASK_OFS) begin
      mask_d = mask_new[mrc_pkg::MRC_IRQ_W-1:0];
    end
    // hardware set wins over a write-one clear in the same cycle
    dis_d = dis_q;
    if (wr_ev && avs_address == mrc_pkg::MRC_CTRL_OFS &&
        wbits[mrc_pkg::MRC_DIS_BIT]) begin
      dis_d = 1'b0;
    end
    if (evt[mrc_pkg::MRC_IRQ_DIS]) begin
      dis_d = 1'b1; // [R10]
    end
    sts_d = sts_q;
    if (wr_ev && avs_address == mrc_pkg::MRC_IRQ_STS_OFS) begin
      sts_d = sts_q & ~wbits[mrc_pkg::MRC_IRQ_W-1:0];
    end
    sts_d = sts_d | evt;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      max_q <= mrc_pkg::MRC_MAX_RST;
      wtl_q <= mrc_pkg::MRC_WTL_RST;
      strip_q <= 1'b0;
      tag_q <= 1'b0;
      on_q <= 1'b0;
      dis_q <= 1'b0;
      sts_q <= '0;
      mask_q <= '0;
    end else begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      max_q <= max_d;
      wtl_q <= wtl_d;
      strip_q <= strip_d;
      tag_q <= tag_d;
      on_q <= on_d;
      dis_q <= dis_d;
      sts_q <= sts_d;
      mask_q <= mask_d;
    end
  end

  // a frame is only joined at its first byte, never mid-way
  assign start = (state_q == mrc_pkg::MRC_IDLE) && phy_rx_dv && !prev_dv_q && on_q; // [R8]
  assign take = start || (state_q == mrc_pkg::MRC_RECV && phy_rx_dv);
  assign base = (state_q == mrc_pkg::MRC_IDLE) ? 15'h0000 : cnt_q;
  assign next_len = base + 15'h0001;

  assign cfg.max_size = max_q;
  assign cfg.strip = strip_q;
  assign cfg.tag_aware = tag_q;
  assign cfg.vld = take;
  assign cfg.sof = start;
  assign cfg.data = phy_rx_data;
  assign cfg.idx = base;

  mrc_tag_limit u_tag (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .cfg(cfg),
    .allowed(allowed)
  );

  mrc_fcs_strip u_strip (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .cfg(cfg),
    .out_valid(rx_data_valid),
    .out_data(rx_data)
  );

  always_comb begin
    cut_len = CUT_LEN; // [R2] [R4]
    if (!wtl_q && (allowed + 15'h0001) < CUT_LEN) begin
      cut_len = allowed + 15'h0001; // [R3]
    end
  end

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    er_d = start ? phy_rx_er : (er_q | (take & phy_rx_er));
    prev_dv_d = phy_rx_dv;
    st_vld_d = 1'b0;
    st_word_d = rx_status_word_a;
    done_long = 1'b0;
    done_cut = 1'b0;
    evt = '0;
    case (state_q)
      mrc_pkg::MRC_IDLE: begin
        if (phy_rx_dv && !start) begin
          state_d = mrc_pkg::MRC_DROP; // [R8]
        end
      end
      mrc_pkg::MRC_RECV: begin
        if (!phy_rx_dv) begin
          state_d = mrc_pkg::MRC_IDLE;
          st_vld_d = 1'b1;
          done_long = cnt_q > allowed; // [R1] [R6] [R7]
          st_word_d = 32'h0000_0000;
          st_word_d[13:0] = cnt_q[13:0];
          st_word_d[mrc_pkg::MRC_ST_LONG_BIT] = done_long;
          st_word_d[mrc_pkg::MRC_ST_ERR_BIT] = er_q;
        end
      end
      mrc_pkg::MRC_DROP: begin
        if (!phy_rx_dv) begin
          state_d = mrc_pkg::MRC_IDLE;
        end
      end
      default: state_d = mrc_pkg::MRC_IDLE;
    endcase
    if (take) begin
      cnt_d = next_len;
      state_d = mrc_pkg::MRC_RECV;
      if (next_len == cut_len) begin
        // truncate here; the rest of the frame is discarded
        state_d = mrc_pkg::MRC_DROP;
        st_vld_d = 1'b1;
        done_long = 1'b1; // [R3] [R4]
        done_cut = next_len == CUT_LEN; // [R2] [R4]
        st_word_d = 32'h0000_0000;
        st_word_d[13:0] = next_len[13:0];
        st_word_d[mrc_pkg::MRC_ST_LONG_BIT] = 1'b1;
        st_word_d[mrc_pkg::MRC_ST_CUT_BIT] = done_cut;
        st_word_d[mrc_pkg::MRC_ST_ERR_BIT] = 1'b1;
      end
    end
    // falling enable arms the shutdown; it completes only when no frame is held
    on_prev_d = on_q;
    pend_d = pend_q;
    if (on_prev_q && !on_q) begin
      pend_d = 1'b1;
    end
    if (on_q) begin
      pend_d = 1'b0;
    end
    if (pend_q && !on_q && state_q == mrc_pkg::MRC_IDLE && !start) begin
      pend_d = 1'b0;
      evt[mrc_pkg::MRC_IRQ_DIS] = 1'b1; // [R9] [R10]
    end
    evt[mrc_pkg::MRC_IRQ_DONE] = st_vld_d;
    evt[mrc_pkg::MRC_IRQ_LONG] = done_long;
    evt[mrc_pkg::MRC_IRQ_CUT] = done_cut;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q <= mrc_pkg::MRC_IDLE;
      cnt_q <= 15'h0000;
      er_q <= 1'b0;
      prev_dv_q <= 1'b0;
      on_prev_q <= 1'b0;
      pend_q <= 1'b0;
      rx_status_valid <= 1'b0;
      rx_status_word_a <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      er_q <= er_d;
      prev_dv_q <= prev_dv_d;
      on_prev_q <= on_prev_d;
      pend_q <= pend_d;
      rx_status_valid <= st_vld_d;
      rx_status_word_a <= st_word_d;
    end
  end
endmodule : mrc_rx_ctrl
`default_nettype wire

// File: testbench/mrc_rx_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module mrc_rx_ctrl_monitor #(
  parameter int unsigned WDT_LEN = mrc_pkg::MRC_WDT_LEN
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic phy_rx_dv,
  input wire logic phy_rx_er,
  input wire logic [7:0] phy_rx_data,
  input wire logic rx_data_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_status_valid,
  input wire logic [31:0] rx_status_word_a,
  input wire logic irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus wait longer than one cycle");
  a_idle_nowait: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("wait without request");
  a_resv_zero: assert property (avs_read && !avs_waitrequest && avs_address == 12'h104
    |-> (avs_readdata & 32'hC000FFC8) == 32'h0) else $error("reserved bits not zero");
  a_len_cap: assert property (rx_status_valid |-> rx_status_word_a[13:0] <= WDT_LEN + 1)
    else $error("length beyond watchdog");
  a_cut_len: assert property (rx_status_valid && rx_status_word_a[15]
    |-> rx_status_word_a[13:0] == 14'(WDT_LEN + 1)) else $error("cut length wrong");
  a_cut_flags: assert property (rx_status_valid && rx_status_word_a[15]
    |-> rx_status_word_a[14] && rx_status_word_a[16]) else $error("cut flags wrong");
  a_cut_quiet: assert property (rx_status_valid && rx_status_word_a[15] |=> !rx_data_valid)
    else $error("data after cut");
  a_data_cause: assert property (rx_data_valid |-> $past(phy_rx_dv))
    else $error("data without byte");
  c_cut: cover property (rx_status_valid && rx_status_word_a[15]);
  c_long: cover property (rx_status_valid && rx_status_word_a[14] && !rx_status_word_a[15]);
  c_irq: cover property (irq);
endmodule : mrc_rx_ctrl_monitor
bind mrc_rx_ctrl mrc_rx_ctrl_monitor #(.WDT_LEN(WDT_LEN)) mrc_rx_ctrl_monitor_i (.*);
`default_nettype wire

// File: testbench/mrc_phy_model.sv
`timescale 1ns/1ps
`default_nettype none
module mrc_phy_model (
  input wire logic sys_clk,
  output logic phy_rx_dv,
  output logic phy_rx_er,
  output logic [7:0] phy_rx_data
);
  logic busy = 1'b0;
  initial begin
    phy_rx_dv = 1'b0;
    phy_rx_er = 1'b0;
    phy_rx_data = 8'hA5;
  end
  // idle data keeps toggling so no stale byte looks valid
  always @(posedge sys_clk) begin
    if (!phy_rx_dv && !busy) phy_rx_data <= ~phy_rx_data;
  end
  task automatic send(input logic [7:0] q[$], input int e);
    busy = 1'b1;
    for (int i = 0; i < q.size(); i++) begin
      phy_rx_dv <= 1'b1;
      phy_rx_er <= (i == e);
      phy_rx_data <= q[i];
      @(posedge sys_clk);
    end
    phy_rx_dv <= 1'b0;
    phy_rx_er <= 1'b0;
    @(posedge sys_clk);
    busy = 1'b0;
  endtask : send
endmodule : mrc_phy_model
`default_nettype wire

// File: testbench/mrc_rx_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module mrc_rx_ctrl_tb_top;
  localparam int WDT = 200;
  logic sys_clk = 1'b0;
  logic sys_rst, avs_read, avs_write, phy_rx_dv, phy_rx_er, avs_waitrequest;
  logic rx_data_valid, rx_status_valid, irq;
  logic [11:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rx_status_word_a, cw;
  logic [3:0] avs_byteenable;
  logic [7:0] phy_rx_data, rx_data;
  logic [31:0] q_dat[$], q_sts[$], q_rd[$];
  int fail_count, n_compared, mx, wl, st, tg, on;
  mrc_rx_ctrl #(.WDT_LEN(WDT)) mrc_rx_ctrl_i (.*);
  mrc_phy_model mrc_phy_model_i (.*);
  always #25 sys_clk = ~sys_clk;
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  always @(posedge sys_clk) begin
    if (rx_data_valid) chk("rx_data", q_dat.size() ? q_dat.pop_front() : 32'hX, 32'(rx_data));
    if (rx_status_valid) chk("status", q_sts.size() ? q_sts.pop_front() : 32'hX, rx_status_word_a);
    if (avs_read && !avs_waitrequest) chk("readdata", q_rd.pop_front(), avs_readdata);
  end
  task automatic bus(logic w, logic [11:0] a, logic [31:0] d);
    int k = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge sys_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    if (k == 20) fail_count++;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask : bus
  task automatic rd(logic [11:0] a, logic [31:0] e);
    q_rd.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd
  task automatic cfg(int m, int w, int s, int t);
    cw = {2'h0, 14'(m), 10'h0, 1'(w), 1'(s), 1'b0, 1'(t), 2'h0};
    bus(1'b1, 12'h104, cw);
    repeat (2) @(posedge sys_clk);
    rd(12'h104, cw | 32'(on * 2));
    bus(1'b1, 12'h104, cw | 32'hC000FFCB);
    rd(12'h104, cw | 32'h1);
    mx = m;
    wl = w;
    st = s;
    tg = t;
    on = 1;
  endtask : cfg
  task automatic frame(int len, int tk, int e);
    logic [7:0] q[$];
    logic [7:0] s;
    int al, cut, lo, n;
    s = 8'($urandom);
    for (int i = 0; i < len; i++) begin
      q.push_back(tk > 0 && i == 12 ? 8'h81 : tk > 0 && i == 13 ? 8'h00 :
        tk > 1 && i == 16 ? 8'h88 : tk > 1 && i == 17 ? 8'hA8 : s + 8'(i));
    end
    al = mx + (tg ? 4 * tk : 0);
    cut = wl ? WDT + 1 : (al + 1 < WDT + 1 ? al + 1 : WDT + 1);
    lo = len >= cut ? cut : len;
    n = st ? lo - 4 : lo;
    if (on) begin
      for (int i = 0; i < n; i++) q_dat.push_back(32'(q[i]));
      q_sts.push_back({15'h0, len >= cut || (e >= 0 && e < lo), len >= cut && cut == WDT + 1,
        lo > al, 14'(lo)});
    end
    mrc_phy_model_i.send(q, e);
    repeat (3) @(posedge sys_clk);
  endtask : frame
  task automatic close_out;
    if (fail_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  initial begin
    #1ms;
    fail_count++;
    close_out();
  end
  initial begin
    sys_rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 12'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    void'($urandom(98));
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    rd(12'h104, 32'h05EE0020);
    rd(12'h200, 32'h0);
    frame(30, 0, -1);
    cfg(40, 0, 0, 0);
    frame(40, 0, -1);
    frame(30, 0, 20);
    frame(60, 0, -1);
    frame(44, 1, -1);
    rd(12'h120, 32'h3);
    chk("irq", 32'h0, 32'(irq));
    bus(1'b1, 12'h124, 32'h2);
    chk("irq", 32'h1, 32'(irq));
    bus(1'b1, 12'h120, 32'h2);
    rd(12'h120, 32'h1);
    chk("irq", 32'h0, 32'(irq));
    cfg(40, 0, 1, 1);
    frame(30, 0, -1);
    frame(44, 1, -1);
    frame(46, 1, -1);
    frame(48, 2, -1);
    frame(49, 2, -1);
    cfg(40, 1, 0, 0);
    frame(60, 0, -1);
    frame(230, 0, -1);
    fork
      frame(30, 0, -1);
      begin
        repeat (5) @(posedge sys_clk);
        bus(1'b1, 12'h104, cw);
        on = 0;
        rd(12'h104, cw);
      end
    join
    repeat (2) @(posedge sys_clk);
    rd(12'h104, cw | 32'h2);
    frame(30, 0, -1);
    chk("left", 32'h0, 32'(q_dat.size() + q_sts.size()));
    close_out();
  end
endmodule : mrc_rx_ctrl_tb_top
`default_nettype wire
